// >>> verilog/thermo_defines.svh
/*
 * Constants of the thermometer serial port: register addresses, field
 * positions, reset values and conversion timing.
 * Assumes inclusion by bare name and a 50 MHz system clock.
 */
`ifndef THERMO_DEFINES_SVH
`define THERMO_DEFINES_SVH

// Register addresses
`define ADDR_CFG_RD 8'h00
`define ADDR_TEMP_LO 8'h01
`define ADDR_TEMP_HI 8'h02
`define ADDR_CFG_WR 8'h80
`define ADDR_LAST_LOW 7'h02
`define ADDR_DIR_BIT 7

// Configuration fields
`define CFG_FIXED 3'b111
`define CFG_ONESHOT_BIT 4
`define CFG_RES_MSB 3
`define CFG_RES_LSB 1
`define CFG_SHUTDOWN_BIT 0
`define CFG_RES_RESET 3'b001
`define CFG_SHUTDOWN_RESET 1'b1
`define CFG_ONESHOT_RESET 1'b0

// Serial framing
`define BIT_LAST 3'h7

// Conversion timing, longest times in ms, rounded down to cycles
`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define CONV_MS_8 75
`define CONV_MS_9 150
`define CONV_MS_10 300
`define CONV_MS_11 600
`define CONV_MS_12 1200
`define CONV_CYC(ms) (((ms) * `NS_PER_MS) / `CLK_PERIOD_NS)

`endif

// >>> verilog/thermo_pkg.sv
/*
 * Types shared by the thermometer serial port and its conversion sequencer.
 * Assumes nothing of its surroundings.
 */
package thermo_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [11:0] sample_t;
  typedef logic [25:0] conv_cnt_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ = 4'b1000
  } port_state_t;
endpackage

// >>> verilog/sync_two_flop.sv
/*
 * Two-flop synchroniser for pins arriving from outside the clock domain.
 * Assumes a synchronous-release active-low reset from the top module.
 */
`timescale 1ns/100ps

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// >>> verilog/conversion_sequencer.sv
/*
 * Conversion sequencer: runs timed conversions in continuous or one-shot
 * mode and stores masked results in the temperature bytes.
 * Assumes the sample input is stable in the system clock domain.
 */
`timescale 1ns/100ps
`include "thermo_defines.svh"

module conversion_sequencer #(
  parameter thermo_pkg::conv_cnt_t CYC_8 = thermo_pkg::conv_cnt_t'(16),
  parameter thermo_pkg::conv_cnt_t CYC_9 = thermo_pkg::conv_cnt_t'(32),
  parameter thermo_pkg::conv_cnt_t CYC_10 = thermo_pkg::conv_cnt_t'(64),
  parameter thermo_pkg::conv_cnt_t CYC_11 = thermo_pkg::conv_cnt_t'(128),
  parameter thermo_pkg::conv_cnt_t CYC_12 = thermo_pkg::conv_cnt_t'(256)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic shutdown_i,
  input wire logic oneshot_req_i,
  input wire logic [2:0] resolution_i,
  input wire thermo_pkg::sample_t temp_sample_i,
  output thermo_pkg::byte_t temp_low_o,
  output thermo_pkg::byte_t temp_high_o,
  output logic oneshot_busy_o,
  output logic converting_o
);
  import thermo_pkg::*;

  logic running_r;
  logic os_run_r;
  logic [2:0] res_r;
  conv_cnt_t cnt_r;
  conv_cnt_t limit_r;
  logic start;
  logic done;
  sample_t keep_mask;

  // Cycle budget for the chosen width; any top-bit code means 12 bits
  function automatic conv_cnt_t conv_limit(input logic [2:0] res);
    unique casez (res)
      3'b000: conv_limit = CYC_8;
      3'b001: conv_limit = CYC_9;
      3'b010: conv_limit = CYC_10;
      3'b011: conv_limit = CYC_11;
      default: conv_limit = CYC_12;
    endcase
  endfunction

  // Clears the fraction bits that the width does not resolve
  function automatic sample_t frac_mask(input logic [2:0] res);
    if (res[2]) begin
      frac_mask = 12'hFFF;
    end else begin
      frac_mask = 12'hFFF << (3'd3 - {1'b0, res[1:0]} + 3'd1);
    end
  endfunction

  assign start = !running_r && (!shutdown_i || oneshot_busy_o);
  assign done = running_r && (cnt_r == limit_r - conv_cnt_t'(1));
  assign converting_o = running_r;

  // Mask kept in a net, since a function result cannot be part-selected
  assign keep_mask = frac_mask(res_r);

  // Never aborted: a shutdown request waits for the running result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      running_r <= 1'b0;
      os_run_r <= 1'b0;
      res_r <= `CFG_RES_RESET;
      cnt_r <= '0;
      limit_r <= '0;
    end else if (start) begin
      running_r <= 1'b1;
      os_run_r <= shutdown_i || oneshot_busy_o;
      res_r <= resolution_i;
      cnt_r <= '0;
      limit_r <= conv_limit(resolution_i);
    end else if (done) begin
      running_r <= 1'b0;
      os_run_r <= 1'b0;
    end else if (running_r) begin
      cnt_r <= cnt_r + conv_cnt_t'(1);
    end
  end

  // Pending one-shot; a new request wins over the completion clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oneshot_busy_o <= `CFG_ONESHOT_RESET;
    end else if (oneshot_req_i) begin
      oneshot_busy_o <= 1'b1;
    end else if (done && os_run_r) begin
      oneshot_busy_o <= 1'b0;
    end
  end

  // Result bytes: integer and sign high, fraction in upper low nibble
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_low_o <= 8'h00;
      temp_high_o <= 8'h00;
    end else if (done) begin
      temp_high_o <= temp_sample_i[11:4];
      temp_low_o <= {temp_sample_i[3:0] & keep_mask[3:0], 4'h0};
    end
  end

  chk_result_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done && res_r == 3'b000 |=> temp_low_o == 8'h00)
    else $error("fraction not cleared at 8-bit width");

  chk_oneshot_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done && os_run_r && !oneshot_req_i |=> !oneshot_busy_o && !running_r)
    else $error("one-shot bit not cleared on completion");
endmodule

// >>> verilog/thermo_serial_port.sv
/*
 * Serial register port of a digital thermometer: four-wire or three-wire
 * slave with configuration and temperature bytes, plus conversion control.
 * Assumes the link pins are asynchronous to clk_i and the shift clock runs
 * well below a quarter of the system clock; the temperature sample comes
 * from a converter on clk_i.
 */
`timescale 1ns/100ps
`include "thermo_defines.svh"

module thermo_serial_port #(
  parameter thermo_pkg::conv_cnt_t CONV_CYC_8 =
    thermo_pkg::conv_cnt_t'(`CONV_CYC(`CONV_MS_8)),
  parameter thermo_pkg::conv_cnt_t CONV_CYC_9 =
    thermo_pkg::conv_cnt_t'(`CONV_CYC(`CONV_MS_9)),
  parameter thermo_pkg::conv_cnt_t CONV_CYC_10 =
    thermo_pkg::conv_cnt_t'(`CONV_CYC(`CONV_MS_10)),
  parameter thermo_pkg::conv_cnt_t CONV_CYC_11 =
    thermo_pkg::conv_cnt_t'(`CONV_CYC(`CONV_MS_11)),
  parameter thermo_pkg::conv_cnt_t CONV_CYC_12 =
    thermo_pkg::conv_cnt_t'(`CONV_CYC(`CONV_MS_12))
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic interface_select_i,
  input wire logic xfer_enable_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_oe_n_o,
  input wire thermo_pkg::sample_t temp_sample_i,
  output logic converting_o
);
  import thermo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic sel_s;
  logic ce_s;
  logic sclk_s;
  logic din_s;
  logic ce_d_r;
  logic sclk_d_r;
  logic ce_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic four_wire_r;
  logic idle_pol_r;
  logic sample_edge;
  logic launch_edge;
  port_state_t state_r;
  port_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  byte_t in_sh_r;
  byte_t in_byte;
  logic byte_done;
  byte_t addr_r;
  byte_t out_sh_r;
  logic oneshot_busy;
  logic shutdown_r;
  logic [2:0] res_r;
  byte_t cfg_view;
  byte_t temp_lo;
  byte_t temp_hi;
  logic cfg_write;
  logic oneshot_req;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  ////////////////////////////////////////////////////////////////////////////

  // Next pointer within the same direction, wrapping after the last byte
  function automatic byte_t next_addr(input byte_t a);
    if (a[6:0] >= `ADDR_LAST_LOW) begin
      next_addr = {a[`ADDR_DIR_BIT], 7'h00};
    end else begin
      next_addr = a + 8'h01;
    end
  endfunction

  // Read map; write addresses and unmapped codes read zero
  function automatic byte_t reg_read(input byte_t a, input byte_t cfg,
                                     input byte_t lo, input byte_t hi);
    case (a)
      `ADDR_CFG_RD: reg_read = cfg;
      `ADDR_TEMP_LO: reg_read = lo;
      `ADDR_TEMP_HI: reg_read = hi;
      default: reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation
  ////////////////////////////////////////////////////////////////////////////

  // Asserted at once, released two edges later
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // All link pins share one synchroniser so their edges stay aligned
  sync_two_flop #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .async_i({interface_select_i, xfer_enable_i, shift_clock_i, serial_in_line_i}),
    .sync_o({sel_s, ce_s, sclk_s, din_s})
  );

  // Delayed copies for edge finding
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ce_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      ce_d_r <= ce_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign ce_rise = ce_s && !ce_d_r;
  assign sclk_rise = sclk_s && !sclk_d_r;
  assign sclk_fall = !sclk_s && sclk_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Frame setup: link type and idle clock level
  ////////////////////////////////////////////////////////////////////////////

  // Caught per frame so a strap change cannot split a transaction
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      four_wire_r <= 1'b1;
      idle_pol_r <= 1'b0;
    end else if (ce_rise && state_r == ST_IDLE) begin
      four_wire_r <= sel_s;
      idle_pol_r <= sclk_s;
    end
  end

  // Four-wire: strobe is the return to idle; three-wire: fixed edges
  assign sample_edge = ce_s && (state_r != ST_IDLE) &&
    (four_wire_r ? (idle_pol_r ? sclk_rise : sclk_fall) : sclk_rise);
  assign launch_edge = ce_s && (state_r == ST_READ) &&
    (four_wire_r ? (idle_pol_r ? sclk_fall : sclk_rise) : sclk_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter
  ////////////////////////////////////////////////////////////////////////////

  // MSB first on four-wire, LSB first on three-wire
  assign in_byte = four_wire_r ? {in_sh_r[6:0], din_s} : {din_s, in_sh_r[7:1]};
  assign byte_done = sample_edge && (bit_cnt_r == `BIT_LAST);

  // Bit count and partial byte, cleared whenever the enable is low
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 3'h0;
      in_sh_r <= 8'h00;
    end else if (!ce_s) begin
      bit_cnt_r <= 3'h0;
      in_sh_r <= 8'h00;
    end else if (sample_edge) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sh_r <= in_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction state
  ////////////////////////////////////////////////////////////////////////////

  // Address byte first, then a run of reads or writes
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (ce_rise) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          state_nxt = in_byte[`ADDR_DIR_BIT] ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: state_nxt = ST_WRITE;
      ST_READ: state_nxt = ST_READ;
      default: state_nxt = ST_IDLE;
    endcase
    if (!ce_s) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Register pointer: loaded by the address, stepped by each data byte
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 8'h00;
    end else if (byte_done && state_r == ST_ADDR) begin
      addr_r <= in_byte;
    end else if (byte_done) begin
      addr_r <= next_addr(addr_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  ////////////////////////////////////////////////////////////////////////////

  // Only 80h writes; 81h and 82h have no target and fall through
  assign cfg_write = byte_done && (state_r == ST_WRITE) &&
    (addr_r == `ADDR_CFG_WR);

  // One-shot honoured only when already in shutdown
  assign oneshot_req = cfg_write && in_byte[`CFG_ONESHOT_BIT] && shutdown_r;

  // Volatile fields, defaults restored on every reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      res_r <= `CFG_RES_RESET;
      shutdown_r <= `CFG_SHUTDOWN_RESET;
    end else if (cfg_write) begin
      res_r <= in_byte[`CFG_RES_MSB:`CFG_RES_LSB];
      shutdown_r <= in_byte[`CFG_SHUTDOWN_BIT];
    end
  end

  // Fixed ones ignore writes; one-shot reads its live pending state
  assign cfg_view = {`CFG_FIXED, oneshot_busy, res_r, shutdown_r};

  ////////////////////////////////////////////////////////////////////////////
  // Conversion control
  ////////////////////////////////////////////////////////////////////////////

  // Runs independently of the port, so reads never disturb a conversion
  conversion_sequencer #(
    .CYC_8(CONV_CYC_8),
    .CYC_9(CONV_CYC_9),
    .CYC_10(CONV_CYC_10),
    .CYC_11(CONV_CYC_11),
    .CYC_12(CONV_CYC_12)
  ) u_conv (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .shutdown_i(shutdown_r),
    .oneshot_req_i(oneshot_req),
    .resolution_i(res_r),
    .temp_sample_i(temp_sample_i),
    .temp_low_o(temp_lo),
    .temp_high_o(temp_hi),
    .oneshot_busy_o(oneshot_busy),
    .converting_o(converting_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter and data line driver
  ////////////////////////////////////////////////////////////////////////////

  // Whole byte loaded at the address and each read byte boundary so output starts only when ready
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= 8'h00;
    end else if (byte_done && state_r == ST_ADDR) begin
      out_sh_r <= reg_read(in_byte, cfg_view, temp_lo, temp_hi);
    end else if (byte_done && state_r == ST_READ) begin
      out_sh_r <= reg_read(next_addr(addr_r), cfg_view, temp_lo, temp_hi);
    end else if (launch_edge) begin
      out_sh_r <= four_wire_r ? {out_sh_r[6:0], 1'b0} : {1'b0, out_sh_r[7:1]};
    end
  end

  // Driver on only after the first launch edge of read data
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_line_o <= 1'b1;
      serial_out_oe_n_o <= 1'b1;
    end else if (!ce_s || state_r != ST_READ) begin
      serial_out_oe_n_o <= 1'b1;
    end else if (launch_edge) begin
      serial_out_line_o <= four_wire_r ? out_sh_r[7] : out_sh_r[0];
      serial_out_oe_n_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////

  chk_released_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
    !ce_s |=> serial_out_oe_n_o && state_r == ST_IDLE && bit_cnt_r == 3'h0)
    else $error("port not reset while enable low");

  chk_no_drive_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_r == ST_WRITE || state_r == ST_ADDR) |-> serial_out_oe_n_o)
    else $error("data line driven outside read data");

  chk_idle_polarity: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_rise && state_r == ST_IDLE |=> idle_pol_r == $past(sclk_s) && four_wire_r == $past(sel_s))
    else $error("idle polarity or link type not captured");

  chk_addr_direction: assert property (@(posedge clk_i) disable iff (!rst_n)
    byte_done && state_r == ST_ADDR && ce_s
      |=> state_r == ($past(in_byte[`ADDR_DIR_BIT]) ? ST_WRITE : ST_READ))
    else $error("address top bit did not pick direction");

  chk_ptr_wrap: assert property (@(posedge clk_i) disable iff (!rst_n)
    byte_done && state_r == ST_READ && addr_r == `ADDR_TEMP_HI |=> addr_r == `ADDR_CFG_RD)
    else $error("read pointer did not wrap");

  chk_oneshot_ignored: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_write && !shutdown_r |-> !oneshot_req ##1 !oneshot_busy || $past(oneshot_busy))
    else $error("one-shot accepted in continuous mode");

  chk_cfg_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    cfg_write |=> res_r == $past(in_byte[3:1]) && shutdown_r == $past(in_byte[0])
      && cfg_view[7:5] == 3'b111)
    else $error("configuration write not stored");

  chk_launch_bit: assert property (@(posedge clk_i) disable iff (!rst_n)
    launch_edge && ce_s |=> serial_out_line_o ==
      ($past(four_wire_r) ? $past(out_sh_r[7]) : $past(out_sh_r[0])) && !serial_out_oe_n_o)
    else $error("wrong bit order on output");
endmodule

// >>> dv/host_master.sv
/*
 * Host master model: frames, shift clock and data for both link flavours.
 * Assumes the bench resolves the shared data wire and feeds it to line_i.
 */
`timescale 1ns/100ps

module host_master
  import thermo_pkg::*;
(
  input wire logic clk_i,
  input wire logic line_i,
  output logic enable_o,
  output logic sclk_o,
  output logic drv_o,
  output logic drv_oe_n_o
);
  initial begin
    enable_o = 1'b0;
    sclk_o = 1'b0;
    drv_o = 1'b0;
    drv_oe_n_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address then n data bytes, clock phase 1 in four-wire
  // Reads are sampled at the end of a bit, clear of the 60 ns output lag
  task automatic frame(input logic four, input logic cpol, input byte_t addr,
    input int n, input byte_t tx [4], output byte_t rx [4]);
    byte_t b;
    int k;
    @(posedge clk_i);
    sclk_o <= four & cpol;
    repeat (2) @(posedge clk_i);
    enable_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int j = 0; j <= n; j++) begin
      b = (j == 0) ? addr : tx[j-1];
      for (int i = 0; i < 8; i++) begin
        k = four ? 7 - i : i;
        sclk_o <= four ? ~cpol : 1'b0;
        // Released line keeps changing so a stale bit cannot pass
        drv_oe_n_o <= !(j == 0 || addr[7]);
        drv_o <= (j == 0 || addr[7]) ? b[k] : ~drv_o;
        repeat (4) @(posedge clk_i);
        sclk_o <= four ? cpol : 1'b1;
        repeat (4) @(posedge clk_i);
        if (j > 0) rx[j-1][k] = line_i;
      end
    end
    drv_oe_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    enable_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// >>> dv/tb.sv
/*
 * Bench for the thermometer serial port: register frames on both links,
 * one-shot and continuous conversions. Assumes host_master drives the link.
 */
`timescale 1ns/100ps

module tb;
  import thermo_pkg::*;
  localparam int CYC [5] = '{200, 240, 280, 320, 360};
  logic clk = 1'b0, resetn = 1'b0, isel = 1'b1, en, sclk, drv, drv_oe_n;
  logic out_line, oe_n, conv, wire_lvl, no_drive = 1'b0;
  sample_t sample = '0;
  byte_t tx [4], rx [4], cfg, d;
  int error_cnt = 0, comparisons = 0, cycles = 0, run = 0, last_len = 0, m, r;
  logic [15:0] t;

  initial begin
    forever #10 clk = ~clk;
  end

  // Shared wire in three-wire mode; a released line floats to the pull-up
  assign wire_lvl = !oe_n ? out_line : (!drv_oe_n ? drv : 1'b1);

  // Four-wire output also pulls up when released, so stale bits cannot pass
  host_master host_u (.clk_i(clk), .line_i(isel ? (oe_n ? 1'b1 : out_line) : wire_lvl),
    .enable_o(en), .sclk_o(sclk), .drv_o(drv), .drv_oe_n_o(drv_oe_n));

  thermo_serial_port #(.CONV_CYC_8(conv_cnt_t'(CYC[0])),
    .CONV_CYC_9(conv_cnt_t'(CYC[1])), .CONV_CYC_10(conv_cnt_t'(CYC[2])),
    .CONV_CYC_11(conv_cnt_t'(CYC[3])), .CONV_CYC_12(conv_cnt_t'(CYC[4]))
  ) dut_u (.clk_i(clk), .resetn_i(resetn), .interface_select_i(isel),
    .xfer_enable_i(en), .shift_clock_i(sclk),
    .serial_in_line_i(isel ? drv : wire_lvl), .serial_out_line_o(out_line),
    .serial_out_oe_n_o(oe_n), .temp_sample_i(sample), .converting_o(conv));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Conversion pulse length, released output in writes, hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (conv === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (no_drive) chk(oe_n, 1'b1);
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic xf(input byte_t a, input int n);
    no_drive = a[7];
    host_u.frame(isel, m == 2, a, n, tx, rx);
    no_drive = 1'b0;
  endtask

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (conv !== v && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk(conv, v);
  endtask

  // Unused fraction bits cleared, low nibble always zero
  function automatic logic [15:0] temp_exp(input sample_t s, input int bits);
    logic [3:0] k;
    k = ~(4'hF >> (bits - 8));
    return {s[11:4], s[3:0] & k, 4'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hd788));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    cfg = 8'hE3;
    t = 16'h0000;
    // Every link flavour: defaults (three-wire only), random config, write and read wrap
    for (m = 0; m < 3; m++) begin
      isel <= (m > 0);
      repeat (4) @(posedge clk);
      xf(8'h00, 1);
      chk(rx[0], cfg);
      foreach (tx[i]) tx[i] = byte_t'($urandom) & 8'hEF | 8'h01;
      cfg = {3'b111, tx[3][4:0]};
      xf(8'h80, 4);
      xf(8'h00, 4);
      chk(rx[0], cfg);
      chk({rx[2], rx[1]}, t);
      chk(rx[3], cfg);
    end
    // One-shot at every resolution; any 1xx code means 12 bits
    for (r = 0; r < 5; r++) begin
      m = r % 3;
      isel <= (m > 0);
      sample <= sample_t'($urandom);
      d = (r == 4) ? (8'hF9 | (byte_t'($urandom) & 8'h06)) : byte_t'(8'hF1 | (r << 1));
      repeat (4) @(posedge clk);
      tx[0] = d;
      xf(8'h80, 1);
      xf(8'h00, 1);
      chk(rx[0], d);
      wait_lvl(1'b0);
      repeat (2) @(posedge clk);
      chk(last_len, CYC[r]);
      xf(8'h01, 2);
      chk({rx[1], rx[0]}, temp_exp(sample, r + 8));
      xf(8'h00, 1);
      chk(rx[0], d & 8'hEF);
      chk(conv, 1'b0);
    end
    // Continuous mode ignores one-shot; shutdown lets the last one finish
    tx[0] = 8'hE0;
    xf(8'h80, 1);
    tx[0] = 8'hF0;
    xf(8'h80, 1);
    xf(8'h00, 1);
    chk(rx[0], 8'hE0);
    sample <= sample_t'($urandom);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    xf(8'h01, 2);
    chk({rx[1], rx[0]}, temp_exp(sample, 8));
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    sample <= sample_t'($urandom);
    tx[0] = 8'hE1;
    xf(8'h80, 1);
    wait_lvl(1'b0);
    repeat (300) @(posedge clk);
    chk(conv, 1'b0);
    chk(last_len, CYC[0]);
    xf(8'h01, 2);
    chk({rx[1], rx[0]}, temp_exp(sample, 8));
    end_of_test();
  end
endmodule
